// ---- bench/pcs_regs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_regs_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic miim_wr,
  input wire logic miim_rd,
  input wire logic miim_rvalid,
  input wire logic p1_rx_flow_active,
  input wire logic p1_speed_100,
  input wire logic p1_power_down,
  input wire logic p1_far_end_fault_off,
  input wire logic p1_crossover_auto_off,
  input wire logic p1_force_mdi,
  input wire logic p1_tx_on_receive_pair,
  input wire logic p2_loopback
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////////
  // decoded register port writes
  wire logic p1_wr = reg_wr && reg_addr == 8'h1d;
  wire logic p2_wr = reg_wr && reg_addr == 8'h2d;

  ////////////////////////////////////////////////////////////////////////////////
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("register read without answer");
  chk_mgmt_answer: assert property (miim_rd |=> miim_rvalid)
    else $error("management read without answer");
  chk_power_write: assert property (p1_wr |=> p1_power_down == $past(reg_wdata[3]))
    else $error("port 1 power-down not written");
  chk_fault_write: assert property (p1_wr |=> p1_far_end_fault_off == $past(reg_wdata[4]))
    else $error("port 1 fault disable not written");
  chk_loop_write: assert property (p2_wr |=> p2_loopback == $past(reg_wdata[0]))
    else $error("port 2 loopback not written");
  chk_control_hold: assert property (!reg_wr && !miim_wr |=> $stable(p1_power_down))
    else $error("port 1 power-down changed without write");
  chk_reserved_zero: assert property (reg_rd && reg_addr inside {8'h3d, 8'h3e}
    |=> reg_rdata == 8'h00)
    else $error("reserved slot read nonzero");
  chk_oper_bits: assert property (reg_rd && reg_addr == 8'h1f && !$past(srst) |=>
    reg_rdata[7:5] == 3'b000 && reg_rdata[4] == $past(p1_rx_flow_active, 2)
    && reg_rdata[2] == $past(p1_speed_100, 2))
    else $error("port 1 operating status wrong");
  chk_xover_force: assert property (p1_crossover_auto_off && $past(p1_crossover_auto_off)
    && $stable(p1_force_mdi) && !$past(srst) |-> p1_tx_on_receive_pair == p1_force_mdi)
    else $error("forced crossover not applied");

  // main scenarios
  cover property (reg_rd && reg_addr == 8'h1f);
  cover property (p2_wr);
  cover property (miim_wr);
endmodule

bind pcs_regs pcs_regs_props u_pcs_regs_props (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .miim_wr(miim_wr), .miim_rd(miim_rd), .miim_rvalid(miim_rvalid),
  .p1_rx_flow_active(p1_rx_flow_active), .p1_speed_100(p1_speed_100),
  .p1_power_down(p1_power_down), .p1_far_end_fault_off(p1_far_end_fault_off),
  .p1_crossover_auto_off(p1_crossover_auto_off), .p1_force_mdi(p1_force_mdi),
  .p1_tx_on_receive_pair(p1_tx_on_receive_pair), .p2_loopback(p2_loopback)
);
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, srst, reg_wr, reg_rd, miim_wr, miim_rd, reg_rvalid, miim_rvalid, s_dis, s_frc;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, p1_st, p2_st, d;
  logic [4:0] miim_phy, miim_reg, p1_op, c1, c2;
  logic [3:0] p2_op, p3_op;
  logic [15:0] miim_wdata, miim_rdata;
  logic p1_pd, p1_xo, p1_fm, p1_ff, p1_lb, p1_tx, p2_pd, p2_xo, p2_fm, p2_lb, p2_tx;
  logic [15:0] reg_q[$];
  logic [15:0] miim_q[$];
  integer mismatches, check_count, cycle_count, seed, i;

  pcs_regs u_pcs_regs (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .miim_phy(miim_phy), .miim_reg(miim_reg), .miim_wr(miim_wr), .miim_rd(miim_rd),
    .miim_wdata(miim_wdata), .miim_rdata(miim_rdata), .miim_rvalid(miim_rvalid),
    .port2_crossover_disable_strap(s_dis), .port2_crossover_strap(s_frc),
    .p1_mdix_resolved(p1_st[7]), .p1_an_done(p1_st[6]), .p1_link_good(p1_st[5]),
    .p1_partner_pause(p1_st[4]), .p1_partner_abilities(p1_st[3:0]),
    .p1_rx_flow_active(p1_op[4]), .p1_tx_flow_active(p1_op[3]), .p1_speed_100(p1_op[2]),
    .p1_full_duplex(p1_op[1]), .p1_far_end_fault(p1_op[0]),
    .p2_mdix_resolved(p2_st[7]), .p2_an_done(p2_st[6]), .p2_link_good(p2_st[5]),
    .p2_partner_pause(p2_st[4]), .p2_partner_abilities(p2_st[3:0]),
    .p2_rx_flow_active(p2_op[3]), .p2_tx_flow_active(p2_op[2]), .p2_speed_100(p2_op[1]),
    .p2_full_duplex(p2_op[0]), .p3_rx_flow_active(p3_op[3]), .p3_tx_flow_active(p3_op[2]),
    .p3_speed_100(p3_op[1]), .p3_full_duplex(p3_op[0]),
    .p1_power_down(p1_pd), .p1_crossover_auto_off(p1_xo), .p1_force_mdi(p1_fm),
    .p1_far_end_fault_off(p1_ff), .p1_loopback(p1_lb), .p1_tx_on_receive_pair(p1_tx),
    .p2_power_down(p2_pd), .p2_crossover_auto_off(p2_xo), .p2_force_mdi(p2_fm),
    .p2_loopback(p2_lb), .p2_tx_on_receive_pair(p2_tx)
  );

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // strobes {reg_wr, reg_rd, miim_wr, miim_rd} held for one cycle
  task automatic go(input logic [3:0] s);
    {reg_wr, reg_rd, miim_wr, miim_rd} = s;
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    go(4'b1000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_q.push_back(16'(e));
    reg_addr = a;
    go(4'b0100);
  endtask

  task automatic mwr(input logic [4:0] p, input logic [15:0] v);
    miim_phy = p;
    miim_reg = 5'h1d;
    miim_wdata = v;
    go(4'b0010);
  endtask

  task automatic mrd(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e);
    miim_q.push_back(e);
    miim_phy = p;
    miim_reg = r;
    go(4'b0001);
  endtask

  task automatic rst(input logic dis, input logic frc);
    go(4'b0000);
    {s_dis, s_frc} = {dis, frc};
    srst = 1'b1;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    c1 = 5'h00;
    c2 = {2'h0, dis, frc, 1'b0};
  endtask

  // control pins against the register model once writes have settled
  task automatic chk_ctl;
    logic [1:0] t;
    t = {c1[2] ? c1[1] : ~p1_st[7], c2[2] ? c2[1] : ~p2_st[7]};
    go(4'b0000);
    go(4'b0000);
    go(4'b0000);
    check("p1 controls", 16'({p1_ff, p1_pd, p1_xo, p1_fm, p1_lb}), 16'(c1));
    check("p2 controls", 16'({p2_pd, p2_xo, p2_fm, p2_lb}), 16'(c2[3:0]));
    check("tx pairs", 16'({p1_tx, p2_tx}), 16'(t));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // answers are compared with the oldest note
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1)
      check("reg_rdata", 16'(reg_rdata), reg_q.pop_front());
    if (miim_rvalid === 1'b1)
      check("miim_rdata", miim_rdata, miim_q.pop_front());
  end

  // hang guard
  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      mismatches++;
      wrap_up;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hc61e;
    mismatches = 0;
    check_count = 0;
    cycle_count = 0;
    {srst, reg_wr, reg_rd, miim_wr, miim_rd, s_dis, s_frc} = 7'h01;
    srst = 1'b1;
    {reg_addr, reg_wdata, p1_st, p2_st, p1_op, p2_op, p3_op} = '0;
    {miim_phy, miim_reg, miim_wdata} = '0;
    // every strap combination through a reset
    for (i = 0; i < 4; i++) begin
      rst(i[1], i[0]);
      rd(8'h2d, {3'h0, c2});
      rd(8'h1d, 8'h00);
      chk_ctl;
    end
    // random controls and status through both access ports
    for (i = 0; i < 24; i++) begin
      {p1_st, p2_st, p1_op, p2_op, p3_op} = 29'($random(seed));
      d = 8'($random(seed));
      if (i[2])
        mwr(i[0] ? 5'h02 : 5'h01, {8'h00, d});
      else
        wr(i[0] ? 8'h2d : 8'h1d, d);
      if (i[0])
        c2 = d[4:0];
      else
        c1 = d[4:0];
      wr(i[1] ? 8'h1f : 8'h3d, ~d);
      mwr(5'h03, 16'hffff);
      rd(8'h1d, {3'h0, c1});
      rd(8'h2d, {3'h0, c2});
      rd(8'h3d, 8'h00);
      rd(8'h3e, 8'h00);
      rd(8'h1e, p1_st);
      rd(8'h2e, p2_st);
      rd(8'h1f, {3'h0, p1_op});
      rd(8'h2f, {3'h0, p2_op, 1'b0});
      rd(8'h3f, {3'h0, p3_op, 1'b0});
      mrd(5'h01, 5'h1e, {8'h00, p1_st});
      mrd(5'h02, 5'h1d, {11'h0, c2});
      mrd(5'h02, 5'h11, 16'h0000);
      chk_ctl;
    end
    check("pending", 16'(reg_q.size() + miim_q.size()), 16'h0000);
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- pkg/pcs_cfg.svh ----
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// register offsets in the switch register map
`define PCS_P1_CTRL_B 8'h1d
`define PCS_P1_PARTNER 8'h1e
`define PCS_P1_OPER 8'h1f
`define PCS_P2_CTRL_B 8'h2d
`define PCS_P2_PARTNER 8'h2e
`define PCS_P2_OPER 8'h2f
`define PCS_P3_CTRL_B 8'h3d
`define PCS_P3_PARTNER 8'h3e
`define PCS_P3_OPER 8'h3f

// control register b field positions
`define PCS_CTRL_FEF_OFF 4
`define PCS_CTRL_POWER_DOWN 3
`define PCS_CTRL_XOVER_OFF 2
`define PCS_CTRL_FORCE_MDI 1
`define PCS_CTRL_LOOPBACK 0
`define PCS_CTRL_WIDTH 5

// partner status field positions
`define PCS_PART_MDIX 7
`define PCS_PART_AN_DONE 6
`define PCS_PART_LINK 5
`define PCS_PART_PAUSE 4

// operating status field positions
`define PCS_OPER_RX_FC 4
`define PCS_OPER_TX_FC 3
`define PCS_OPER_SPEED 2
`define PCS_OPER_DUPLEX 1
`define PCS_OPER_FEF 0

// reset values
`define PCS_STATUS_RESET 8'h00
`define PCS_CTRL_RESET 5'h00

// management (two-wire) access: phy addresses and register indices
`define PCS_MIIM_PHY_P1 5'h01
`define PCS_MIIM_PHY_P2 5'h02
`define PCS_MIIM_CTRL_REG 5'h1d
`define PCS_MIIM_STATUS_REG 5'h1e

`endif

// ---- pkg/pcs_pkg.sv ----
package pcs_pkg;

  // kind of register an offset selects within a port slot
  typedef enum logic [1:0] {
    PCS_SEL_NONE,
    PCS_SEL_CTRL,
    PCS_SEL_PARTNER,
    PCS_SEL_OPER
  } pcs_sel_type;

  // port slot an offset falls in
  typedef enum logic [1:0] {
    PCS_PORT_NONE,
    PCS_PORT_1,
    PCS_PORT_2,
    PCS_PORT_3
  } pcs_port_type;

endpackage

// ---- src/pcs_port_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"

module pcs_port_ctrl #(
  parameter bit FIBER_PORT = 1'b0,
  parameter bit STRAPPED = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic strap_xover_off,
  input wire logic strap_force_mdi,
  input wire logic wr_en,
  input wire logic [4:0] wr_data,
  input wire logic mdix_resolved,
  output logic [4:0] ctrl,
  output logic power_down,
  output logic xover_auto_off,
  output logic force_mdi,
  output logic fef_off,
  output logic loopback,
  output logic tx_on_receive_pair
);

  logic [4:0] reset_value;
  logic [4:0] next_ctrl;
  logic next_tx_pair;

  // reset value: straps only on the strapped port, sampled while srst is high
  // crossover strap
  assign reset_value = STRAPPED ?
    {2'b00, strap_xover_off, strap_force_mdi, 1'b0} : `PCS_CTRL_RESET;
  assign next_ctrl = wr_en ? wr_data : ctrl;
  assign next_tx_pair = next_ctrl[`PCS_CTRL_XOVER_OFF] ?
    next_ctrl[`PCS_CTRL_FORCE_MDI] : !mdix_resolved;

  // control bits and the phy controls they steer
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= reset_value;
      power_down <= 1'b0;
      xover_auto_off <= reset_value[`PCS_CTRL_XOVER_OFF];
      force_mdi <= reset_value[`PCS_CTRL_FORCE_MDI];
      fef_off <= 1'b0;
      loopback <= 1'b0;
      tx_on_receive_pair <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      power_down <= next_ctrl[`PCS_CTRL_POWER_DOWN];
      xover_auto_off <= next_ctrl[`PCS_CTRL_XOVER_OFF];
      force_mdi <= next_ctrl[`PCS_CTRL_FORCE_MDI];
      fef_off <= FIBER_PORT & next_ctrl[`PCS_CTRL_FEF_OFF];
      loopback <= next_ctrl[`PCS_CTRL_LOOPBACK];
      tx_on_receive_pair <= next_tx_pair;
    end
  end

endmodule
`default_nettype wire

// ---- src/pcs_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"

module pcs_regs (
  input wire logic clk,
  input wire logic srst,
  // switch register access port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // two-wire management access, already deserialised
  input wire logic [4:0] miim_phy,
  input wire logic [4:0] miim_reg,
  input wire logic miim_wr,
  input wire logic miim_rd,
  input wire logic [15:0] miim_wdata,
  output logic [15:0] miim_rdata,
  output logic miim_rvalid,
  // strap pins, read during reset
  input wire logic port2_crossover_disable_strap,
  input wire logic port2_crossover_strap,
  // port 1 phy state
  input wire logic p1_mdix_resolved,
  input wire logic p1_an_done,
  input wire logic p1_link_good,
  input wire logic p1_partner_pause,
  input wire logic [3:0] p1_partner_abilities,
  input wire logic p1_rx_flow_active,
  input wire logic p1_tx_flow_active,
  input wire logic p1_speed_100,
  input wire logic p1_full_duplex,
  input wire logic p1_far_end_fault,
  // port 2 phy state
  input wire logic p2_mdix_resolved,
  input wire logic p2_an_done,
  input wire logic p2_link_good,
  input wire logic p2_partner_pause,
  input wire logic [3:0] p2_partner_abilities,
  input wire logic p2_rx_flow_active,
  input wire logic p2_tx_flow_active,
  input wire logic p2_speed_100,
  input wire logic p2_full_duplex,
  // port 3 mac state
  input wire logic p3_rx_flow_active,
  input wire logic p3_tx_flow_active,
  input wire logic p3_speed_100,
  input wire logic p3_full_duplex,
  // port 1 phy controls
  output logic p1_power_down,
  output logic p1_crossover_auto_off,
  output logic p1_force_mdi,
  output logic p1_far_end_fault_off,
  output logic p1_loopback,
  output logic p1_tx_on_receive_pair,
  // port 2 phy controls
  output logic p2_power_down,
  output logic p2_crossover_auto_off,
  output logic p2_force_mdi,
  output logic p2_loopback,
  output logic p2_tx_on_receive_pair
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [4:0] p1_ctrl;
  logic [4:0] p2_ctrl;
  logic [7:0] p1_partner;
  logic [7:0] p2_partner;
  logic [7:0] p1_oper;
  logic [7:0] p2_oper;
  logic [7:0] p3_oper;
  logic [7:0] next_p1_partner;
  logic [7:0] next_p2_partner;
  logic [7:0] next_p1_oper;
  logic [7:0] next_p2_oper;
  logic [7:0] next_p3_oper;
  logic [7:0] miim_addr;
  logic miim_hit;
  logic reg_wr_p1;
  logic reg_wr_p2;
  logic miim_wr_p1;
  logic miim_wr_p2;
  logic p1_wr_en;
  logic p2_wr_en;
  logic [4:0] p1_wr_data;
  logic [4:0] p2_wr_data;
  logic [7:0] reg_read_value;
  logic [7:0] miim_read_value;
  logic miim_phy_p1;
  logic miim_phy_p2;
  logic miim_reg_ctrl;
  logic miim_reg_status;

  ////////////////////////////////////////////////////////////////////////////
  // address decoding

  // port slot of an offset
  function automatic pcs_pkg::pcs_port_type port_of(input logic [7:0] addr);
    unique case (addr[7:4])
      4'h1: port_of = pcs_pkg::PCS_PORT_1;
      4'h2: port_of = pcs_pkg::PCS_PORT_2;
      4'h3: port_of = pcs_pkg::PCS_PORT_3;
      default: port_of = pcs_pkg::PCS_PORT_NONE;
    endcase
  endfunction

  // register kind of an offset within its slot
  function automatic pcs_pkg::pcs_sel_type sel_of(input logic [7:0] addr);
    unique case (addr[3:0])
      4'hd: sel_of = pcs_pkg::PCS_SEL_CTRL;
      4'he: sel_of = pcs_pkg::PCS_SEL_PARTNER;
      4'hf: sel_of = pcs_pkg::PCS_SEL_OPER;
      default: sel_of = pcs_pkg::PCS_SEL_NONE;
    endcase
  endfunction

  // read value of an offset; reserved and unmapped offsets read zero
  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    logic [7:0] value;
    value = 8'h00;
    unique case (addr)
      `PCS_P1_CTRL_B: value = {3'b000, p1_ctrl};
      `PCS_P2_CTRL_B: value = {3'b000, p2_ctrl};
      `PCS_P1_PARTNER: value = p1_partner;
      `PCS_P2_PARTNER: value = p2_partner;
      `PCS_P1_OPER: value = p1_oper;
      `PCS_P2_OPER: value = p2_oper;
      `PCS_P3_OPER: value = p3_oper;
      `PCS_P3_CTRL_B: value = 8'h00;
      `PCS_P3_PARTNER: value = 8'h00;
      default: value = 8'h00;
    endcase
    read_mux = value;
  endfunction

  // write strobe for one port's control b register
  function automatic logic ctrl_write(input logic wr, input logic [7:0] addr,
                                      input pcs_pkg::pcs_port_type port);
    ctrl_write = wr && (port_of(addr) == port) &&
                 (sel_of(addr) == pcs_pkg::PCS_SEL_CTRL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // management access mapped onto the same offsets

  // which phy and which register a management request names
  assign miim_phy_p1 = (miim_phy == `PCS_MIIM_PHY_P1);
  assign miim_phy_p2 = (miim_phy == `PCS_MIIM_PHY_P2);
  assign miim_reg_ctrl = (miim_reg == `PCS_MIIM_CTRL_REG);
  assign miim_reg_status = (miim_reg == `PCS_MIIM_STATUS_REG);

  assign miim_hit = (miim_phy_p1 || miim_phy_p2) && (miim_reg_ctrl || miim_reg_status);
  assign miim_addr = !miim_hit ? 8'h00 :
                     {miim_phy_p1 ? 4'h1 : 4'h2, miim_reg_ctrl ? 4'hd : 4'he};

  ////////////////////////////////////////////////////////////////////////////
  // control writes: the register port wins over management on a clash

  assign reg_wr_p1 = ctrl_write(reg_wr, reg_addr, pcs_pkg::PCS_PORT_1);
  assign reg_wr_p2 = ctrl_write(reg_wr, reg_addr, pcs_pkg::PCS_PORT_2);
  assign miim_wr_p1 = ctrl_write(miim_wr, miim_addr, pcs_pkg::PCS_PORT_1);
  assign miim_wr_p2 = ctrl_write(miim_wr, miim_addr, pcs_pkg::PCS_PORT_2);
  assign p1_wr_en = reg_wr_p1 || miim_wr_p1;
  assign p2_wr_en = reg_wr_p2 || miim_wr_p2;
  assign p1_wr_data = reg_wr_p1 ? reg_wdata[4:0] : miim_wdata[4:0];
  assign p2_wr_data = reg_wr_p2 ? reg_wdata[4:0] : miim_wdata[4:0];

  ////////////////////////////////////////////////////////////////////////////
  // per-port control registers

  // port 1: fiber capable, no straps; loopback returns port 2 traffic
  // far-end fault disable
  pcs_port_ctrl #(
    .FIBER_PORT(1'b1),
    .STRAPPED(1'b0)
  ) u_port1 (
    .clk(clk),
    .srst(srst),
    .strap_xover_off(1'b0),
    .strap_force_mdi(1'b0),
    .wr_en(p1_wr_en),
    .wr_data(p1_wr_data),
    .mdix_resolved(p1_mdix_resolved),
    .ctrl(p1_ctrl),
    .power_down(p1_power_down),
    .xover_auto_off(p1_crossover_auto_off),
    .force_mdi(p1_force_mdi),
    .fef_off(p1_far_end_fault_off),
    .loopback(p1_loopback),
    .tx_on_receive_pair(p1_tx_on_receive_pair)
  );

  // port 2: copper only, crossover straps; loopback returns port 1 traffic
  // strap for crossover
  pcs_port_ctrl #(
    .FIBER_PORT(1'b0),
    .STRAPPED(1'b1)
  ) u_port2 (
    .clk(clk),
    .srst(srst),
    .strap_xover_off(port2_crossover_disable_strap),
    .strap_force_mdi(port2_crossover_strap),
    .wr_en(p2_wr_en),
    .wr_data(p2_wr_data),
    .mdix_resolved(p2_mdix_resolved),
    .ctrl(p2_ctrl),
    .power_down(p2_power_down),
    .xover_auto_off(p2_crossover_auto_off),
    .force_mdi(p2_force_mdi),
    .fef_off(), // no fiber on port 2: fault control drives nothing
    .loopback(p2_loopback),
    .tx_on_receive_pair(p2_tx_on_receive_pair)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status register assembly

  assign next_p1_partner = {p1_mdix_resolved, p1_an_done, p1_link_good,
                            p1_partner_pause, p1_partner_abilities};
  assign next_p2_partner = {p2_mdix_resolved, p2_an_done, p2_link_good,
                            p2_partner_pause, p2_partner_abilities};

  assign next_p1_oper = {3'b000, p1_rx_flow_active, p1_tx_flow_active,
                         p1_speed_100, p1_full_duplex, p1_far_end_fault};
  assign next_p2_oper = {3'b000, p2_rx_flow_active, p2_tx_flow_active,
                         p2_speed_100, p2_full_duplex, 1'b0};
  assign next_p3_oper = {3'b000, p3_rx_flow_active, p3_tx_flow_active,
                         p3_speed_100, p3_full_duplex, 1'b0};

  // partner status snapshots, refreshed every cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      p1_partner <= `PCS_STATUS_RESET;
      p2_partner <= `PCS_STATUS_RESET;
    end else begin
      p1_partner <= next_p1_partner;
      p2_partner <= next_p2_partner;
    end
  end

  // phy port operating status snapshots
  always_ff @(posedge clk) begin
    if (srst) begin
      p1_oper <= `PCS_STATUS_RESET;
      p2_oper <= `PCS_STATUS_RESET;
    end else begin
      p1_oper <= next_p1_oper;
      p2_oper <= next_p2_oper;
    end
  end

  // mac port operating status snapshot
  always_ff @(posedge clk) begin
    if (srst) begin
      p3_oper <= `PCS_STATUS_RESET;
    end else begin
      p3_oper <= next_p3_oper;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answers, one cycle after the strobe

  assign reg_read_value = read_mux(reg_addr);
  assign miim_read_value = miim_hit ? read_mux(miim_addr) : 8'h00;

  // register port answer strobe, one cycle after the read
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // register port read data, held until the next read
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= reg_read_value;
    end
  end

  // management answer strobe, one cycle after the read
  always_ff @(posedge clk) begin
    if (srst) begin
      miim_rvalid <= 1'b0;
    end else begin
      miim_rvalid <= miim_rd;
    end
  end

  // management read data, upper byte zero, held until the next read
  always_ff @(posedge clk) begin
    if (srst) begin
      miim_rdata <= 16'h0000;
    end else if (miim_rd) begin
      miim_rdata <= {8'h00, miim_read_value};
    end
  end

endmodule
`default_nettype wire
